// ---- rtl/ccfg_pkg.sv ----
// constants and types of the channel enable and power configuration bank
package ccfg_pkg;
   localparam int unsigned NUM_CH = 8;

   localparam logic [7:0] ADDR_INPUT_CHANNEL_ENABLE = 8'h73;
   localparam logic [7:0] ADDR_OUTPUT_SLOT_ENABLE   = 8'h74;
   localparam logic [7:0] ADDR_POWER_CONFIGURATION  = 8'h75;
   localparam logic [7:0] ADDR_CHANNEL_POWER_STATUS = 8'h76;
   localparam logic [7:0] ADDR_DEVICE_MODE_STATUS   = 8'h77;

   localparam logic [7:0] RST_INPUT_CHANNEL_ENABLE = 8'hF0;
   localparam logic [7:0] RST_OUTPUT_SLOT_ENABLE   = 8'h00;
   localparam logic [7:0] RST_POWER_CONFIGURATION  = 8'h00;
   localparam logic [7:0] ZERO_BYTE                = 8'h00;

   // power_configuration fields
   localparam int unsigned MIC_BIAS_BIT   = 7;
   localparam int unsigned CONV_POWER_BIT = 6;
   localparam int unsigned PLL_POWER_BIT  = 5;
   localparam int unsigned DYN_POWER_BIT  = 4;
   localparam int unsigned RANGE_HI_BIT   = 3;
   localparam int unsigned RANGE_LO_BIT   = 2;

   // device_mode_status field
   localparam int unsigned MODE_HI_BIT = 7;
   localparam int unsigned MODE_LO_BIT = 5;

   typedef logic [2:0] ccfg_mode_t;
   localparam ccfg_mode_t MODE_SLEEP      = 3'h4;
   localparam ccfg_mode_t MODE_ACTIVE_OFF = 3'h6;
   localparam ccfg_mode_t MODE_ACTIVE_ON  = 3'h7;

   typedef logic [1:0] ccfg_range_t;
   localparam ccfg_range_t RANGE_CH2 = 2'h0;
   localparam ccfg_range_t RANGE_CH4 = 2'h1;
   localparam ccfg_range_t RANGE_CH6 = 2'h2;
   localparam ccfg_range_t RANGE_CH8 = 2'h3;

   typedef enum logic [1:0] {
      CCFG_IDLE,
      CCFG_ACTIVE_OFF,
      CCFG_RECORDING
   } ccfg_state_e;
endpackage : ccfg_pkg

// ---- rtl/ccfg_power_if.sv ----
// control and status bundle between the bank and its helper modules
`timescale 1ns/10ps
interface ccfg_power_if;
   import ccfg_pkg::*;
   logic [7:0]  input_channel_enable;
   logic [7:0]  output_slot_enable;
   logic        converter_power_on;
   logic        dynamic_channel_power_enable;
   ccfg_range_t dynamic_channel_range_select;
   logic        recording;
   logic [7:0]  channel_power;
   logic [7:0]  slot_drive_enable;

   modport ctrl (
      output input_channel_enable,
      output output_slot_enable,
      output converter_power_on,
      output dynamic_channel_power_enable,
      output dynamic_channel_range_select,
      output recording,
      input  channel_power,
      input  slot_drive_enable
   );
   modport chan (
      input  input_channel_enable,
      input  converter_power_on,
      input  dynamic_channel_power_enable,
      input  dynamic_channel_range_select,
      input  recording,
      output channel_power
   );
   modport slot (
      input  output_slot_enable,
      output slot_drive_enable
   );
endinterface : ccfg_power_if

// ---- rtl/ccfg_chan_power.sv ----
// per-channel power state, bit 7 is channel 1
`timescale 1ns/10ps
module ccfg_chan_power
   import ccfg_pkg::*;
(
   input wire logic   clock,
   input wire logic   sys_rst,
   ccfg_power_if.chan pwr
);
   logic [7:0] power_q;
   logic [7:0] power_d;
   logic [3:0] range_top;

   always_comb begin
      case (pwr.dynamic_channel_range_select)
         RANGE_CH2: range_top = 4'h2;
         RANGE_CH4: range_top = 4'h4;
         RANGE_CH6: range_top = 4'h6;
         default:   range_top = 4'h8;
      endcase
   end

   for (genvar b = 0; b < NUM_CH; b++) begin : g_ch
      localparam logic [3:0] CH_NUM = 4'(NUM_CH - b);
      always_comb begin
         if (!pwr.converter_power_on) begin
            power_d[b] = 1'b0; // [R06]
         end else if (!pwr.recording) begin
            power_d[b] = pwr.input_channel_enable[b]; // [R01] [R06]
         end else if (pwr.dynamic_channel_power_enable
                      && CH_NUM <= range_top) begin
            power_d[b] = pwr.input_channel_enable[b]; // [R09] [R10]
         end else begin
            power_d[b] = power_q[b]; // [R08]
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_q <= ZERO_BYTE;
      end else begin
         power_q <= power_d;
      end
   end

   assign pwr.channel_power = power_q;
endmodule : ccfg_chan_power

// ---- rtl/ccfg_slot_drive.sv ----
// output slot drive enables of the audio serial interface
`timescale 1ns/10ps
module ccfg_slot_drive
   import ccfg_pkg::*;
(
   input wire logic   clock,
   input wire logic   sys_rst,
   ccfg_power_if.slot pwr
);
   logic [7:0] drive_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         drive_q <= RST_OUTPUT_SLOT_ENABLE; // [R04]
      end else begin
         drive_q <= pwr.output_slot_enable; // [R03]
      end
   end

   assign pwr.slot_drive_enable = drive_q;
endmodule : ccfg_slot_drive

// ---- rtl/ccfg_bank.sv ----
// channel enable and power configuration register bank
//
// How it works
// R01: one enable per input channel, bit 7 is channel 1, one enables.
// R02: channels five to eight pdm only, reset disabled; one to four enabled.
// R03: each output slot is driven when its enable is one, else tri-stated.
// R04: all output slot enables reset to zero.
// R05: power bit 7 switches microphone bias, resets off.
// R06: power bit 6 zero powers all channels down; one powers enabled ones.
// R07: power bit 5 switches the pll, resets off.
// R08: dynamic bit zero freezes channel power while anything records.
// R09: dynamic bit one allows per-channel changes; host keeps channel one on.
// R10: bits 3-2 pick channels 1-2, 1-4, 1-6 or 1-8 for dynamic mode.
// R11: mode status reads 4 sleep, 6 active idle, 7 active recording.
// R12: read-only power status bit per channel, one when powered.
`timescale 1ns/10ps
module ccfg_bank
   import ccfg_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       sleep_req,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   output logic            mic_bias_power_on,
   output logic            pll_power_on,
   output logic      [7:0] channel_power,
   output logic      [7:0] slot_drive_enable
);
   logic [7:0]  input_channel_enable_q;
   logic [7:0]  output_slot_enable_q;
   logic [7:0]  power_configuration_q;
   ccfg_state_e state_q;
   ccfg_state_e state_d;
   ccfg_mode_t  mode_val;
   logic [7:0]  rdata_q;
   logic        rvalid_q;
   logic        mic_bias_q;
   logic        pll_q;
   logic [7:0]  mode_byte;

   ccfg_power_if pwr ();

   // software-written registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         input_channel_enable_q <= RST_INPUT_CHANNEL_ENABLE; // [R02]
      end else if (reg_wr && reg_addr == ADDR_INPUT_CHANNEL_ENABLE) begin
         input_channel_enable_q <= reg_wdata; // [R01]
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         output_slot_enable_q <= RST_OUTPUT_SLOT_ENABLE; // [R04]
      end else if (reg_wr && reg_addr == ADDR_OUTPUT_SLOT_ENABLE) begin
         output_slot_enable_q <= reg_wdata; // [R03]
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_configuration_q <= RST_POWER_CONFIGURATION;
      end else if (reg_wr && reg_addr == ADDR_POWER_CONFIGURATION) begin
         power_configuration_q <= reg_wdata;
      end
   end

   // steering into the helper modules
   assign pwr.input_channel_enable = input_channel_enable_q;
   assign pwr.output_slot_enable   = output_slot_enable_q;
   assign pwr.converter_power_on   =
      power_configuration_q[CONV_POWER_BIT] && !sleep_req; // [R06]
   assign pwr.dynamic_channel_power_enable =
      power_configuration_q[DYN_POWER_BIT]; // [R08] [R09]
   assign pwr.dynamic_channel_range_select =
      power_configuration_q[RANGE_HI_BIT:RANGE_LO_BIT]; // [R10]
   assign pwr.recording = (state_q == CCFG_RECORDING);

   ccfg_chan_power u_chan_power (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pwr     (pwr.chan)
   );

   ccfg_slot_drive u_slot_drive (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pwr     (pwr.slot)
   );

   // analog power switches
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mic_bias_q <= 1'b0;
         pll_q      <= 1'b0;
      end else begin
         mic_bias_q <= power_configuration_q[MIC_BIAS_BIT]
                       && !sleep_req; // [R05]
         pll_q      <= power_configuration_q[PLL_POWER_BIT]
                       && !sleep_req; // [R07]
      end
   end

   // device mode tracking
   always_comb begin
      case (state_q)
         CCFG_IDLE:       state_d = CCFG_ACTIVE_OFF;
         CCFG_ACTIVE_OFF: state_d = CCFG_RECORDING;
         CCFG_RECORDING:  state_d = CCFG_ACTIVE_OFF;
         default:         state_d = CCFG_IDLE;
      endcase
      if (sleep_req) begin
         state_d = CCFG_IDLE;
      end else if (pwr.channel_power != ZERO_BYTE) begin
         state_d = CCFG_RECORDING;
      end else begin
         state_d = CCFG_ACTIVE_OFF;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= CCFG_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      case (state_q)
         CCFG_ACTIVE_OFF: mode_val = MODE_ACTIVE_OFF; // [R11]
         CCFG_RECORDING:  mode_val = MODE_ACTIVE_ON; // [R11]
         default:         mode_val = MODE_SLEEP; // [R11]
      endcase
      mode_byte = ZERO_BYTE;
      mode_byte[MODE_HI_BIT:MODE_LO_BIT] = mode_val;
   end

   // register read port
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q  <= ZERO_BYTE;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               ADDR_INPUT_CHANNEL_ENABLE: rdata_q <= input_channel_enable_q;
               ADDR_OUTPUT_SLOT_ENABLE:   rdata_q <= output_slot_enable_q;
               ADDR_POWER_CONFIGURATION:  rdata_q <= power_configuration_q;
               ADDR_CHANNEL_POWER_STATUS: rdata_q <= channel_power; // [R12]
               ADDR_DEVICE_MODE_STATUS:   rdata_q <= mode_byte; // [R11]
               default:                   rdata_q <= ZERO_BYTE;
            endcase
         end
      end
   end

   assign reg_rdata         = rdata_q;
   assign reg_rvalid        = rvalid_q;
   assign mic_bias_power_on = mic_bias_q;
   assign pll_power_on      = pll_q;
   assign channel_power     = pwr.channel_power; // [R06] [R12]
   assign slot_drive_enable = pwr.slot_drive_enable; // [R03]
endmodule : ccfg_bank

// ---- testbench/ccfg_bank_monitor.sv ----
// port assertions of the configuration bank
`timescale 1ns/10ps
module ccfg_bank_monitor
   import ccfg_pkg::*;
(
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       sleep_req,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic       mic_bias_power_on,
   input wire logic       pll_power_on,
   input wire logic [7:0] channel_power,
   input wire logic [7:0] slot_drive_enable
);
   logic pw;
   assign pw = reg_wr && (reg_addr == ADDR_POWER_CONFIGURATION);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_read_valid: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_sleep_off: assert property (sleep_req ##1 sleep_req |->
      !mic_bias_power_on && !pll_power_on && channel_power == ZERO_BYTE)
      else $error("power on in sleep");
   a_bias_follow: assert property (pw ##1 !sleep_req [*2] |->
      mic_bias_power_on == $past(reg_wdata[MIC_BIAS_BIT], 2))
      else $error("bias wrong");
   a_pll_follow: assert property (pw ##1 !sleep_req [*2] |->
      pll_power_on == $past(reg_wdata[PLL_POWER_BIT], 2))
      else $error("pll wrong");
   a_slot_follow: assert property (reg_wr &&
      reg_addr == ADDR_OUTPUT_SLOT_ENABLE |=> ##1
      slot_drive_enable == $past(reg_wdata, 2))
      else $error("slot drive wrong");
   a_conv_off: assert property (pw && !reg_wdata[CONV_POWER_BIT]
      |=> ##1 channel_power == ZERO_BYTE)
      else $error("channel on with converter off");
   a_mode_read: assert property (reg_rd && !sleep_req &&
      reg_addr == ADDR_DEVICE_MODE_STATUS && !$past(sleep_req) &&
      !$past(sys_rst) && $stable(channel_power) |=>
      reg_rdata[MODE_HI_BIT:MODE_LO_BIT] == (($past(channel_power) != 0)
      ? MODE_ACTIVE_ON : MODE_ACTIVE_OFF))
      else $error("mode status wrong");
   a_status_read: assert property (reg_rd &&
      reg_addr == ADDR_CHANNEL_POWER_STATUS && $stable(channel_power)
      |=> reg_rdata == $past(channel_power))
      else $error("power status wrong");
endmodule : ccfg_bank_monitor
bind ccfg_bank ccfg_bank_monitor mon_u (.*);

// ---- testbench/ccfg_host.sv ----
// control port host model
`timescale 1ns/10ps
module ccfg_host
   import ccfg_pkg::*;
(
   input  wire logic       clock,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // callers keep channel one enabled in dynamic mode
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clock);
      v = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
   endtask : rd
endmodule : ccfg_host

// ---- testbench/tb_top.sv ----
// self-checking bench of the configuration bank
`timescale 1ns/10ps
module tb_top;
   import ccfg_pkg::*;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic       sleep_req = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [7:0] channel_power, slot_drive_enable;
   logic       reg_wr, reg_rd, reg_rvalid, mic_bias_power_on, pll_power_on;
   int         n_fail = 0;
   int         check_count = 0;
   int         cyc = 0;
   int         r;
   ccfg_host host_u (.clock(clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   ccfg_bank dut_u (.clock(clock), .sys_rst(sys_rst), .sleep_req(sleep_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .mic_bias_power_on(mic_bias_power_on), .pll_power_on(pll_power_on),
      .channel_power(channel_power), .slot_drive_enable(slot_drive_enable));
   initial forever #50 clock = ~clock;
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      host_u.rd(a, d);
      chk(d, exp);
   endtask : rdc
   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask : settle
   task automatic do_rst;
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
   endtask : do_rst
   task automatic rst_check;
      chk(channel_power | slot_drive_enable, 8'h00);
      rdc(8'h73, 8'hF0);
      rdc(8'h74, 8'h00);
      rdc(8'h75, 8'h00);
      rdc(8'h76, 8'h00);
      rdc(8'h77, 8'hC0);
      $display("test reset done");
   endtask : rst_check
   initial begin
      do_rst();
      rst_check();
      host_u.wr(8'h74, 8'hA5);
      settle();
      chk(slot_drive_enable, 8'hA5);
      rdc(8'h74, 8'hA5);
      host_u.wr(8'h73, 8'hC3);
      host_u.wr(8'h75, 8'hE3);
      settle();
      chk({mic_bias_power_on, pll_power_on, 6'h00}, 8'hC0);
      chk(channel_power, 8'hC3);
      rdc(8'h75, 8'hE3);
      rdc(8'h76, 8'hC3);
      rdc(8'h77, 8'hE0);
      host_u.wr(8'h73, 8'hF0);
      settle();
      chk(channel_power, 8'hC3);
      host_u.wr(8'h75, 8'h00);
      settle();
      chk(channel_power, 8'h00);
      rdc(8'h77, 8'hC0);
      rdc(8'h10, 8'h00);
      $display("test static power done");
      for (r = 0; r < 4; r++) begin
         host_u.wr(8'h75, 8'h00);
         host_u.wr(8'h73, 8'h80);
         host_u.wr(8'h75, {4'h5, 2'(r), 2'h0});
         host_u.wr(8'h73, 8'hFF);
         settle();
         chk(channel_power, ~(8'hFF >> (2 * r + 2)));
      end
      $display("test dynamic range done");
      host_u.wr(8'h75, 8'hE0);
      @(posedge clock);
      sleep_req <= 1'b1;
      settle();
      chk({mic_bias_power_on, pll_power_on, 6'h00}, 8'h00);
      chk(channel_power, 8'h00);
      rdc(8'h77, 8'h80);
      @(posedge clock);
      sleep_req <= 1'b0;
      settle();
      chk(channel_power, 8'hFF);
      $display("test sleep done");
      do_rst();
      rst_check();
      final_report();
   end
endmodule : tb_top
